// ===== include/ctcdc_pkg.sv
package ctcdc_pkg;
  localparam int CTCDC_NCH = 4;
  // control word fields
  localparam int CW_IRQ_EN_BIT = 7;
  localparam int CW_MODE_BIT = 6;
  localparam int CW_PRESC_BIT = 5;
  localparam int CW_SLOPE_BIT = 4;
  localparam int CW_TRIG_BIT = 3;
  localparam int CW_TC_NEXT_BIT = 2;
  localparam int CW_SWRST_BIT = 1;
  localparam int CW_CTRL_BIT = 0;
  // vector layout
  localparam int VEC_HI_LSB = 3;
  localparam int VEC_CH_LSB = 1;
  // return-from-interrupt opcode bytes
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_BYTE0 = 8'hed;
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_BYTE1 = 8'h4d;
  // prescaler counts
  localparam logic [7:0] PRESC_SHORT = 8'h0f;
  localparam logic [7:0] PRESC_LONG = 8'hff;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [4:0] RST_VEC_HI = 5'h00;
  // trigger lead time, and clock rate
  localparam int TRIG_LEAD_NS = 210;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TRIG_LEAD_CYC = (TRIG_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // zero-count pulse width in clocks
  localparam int ZC_PULSE_CYC = 1;

  typedef enum logic [1:0] {CTCDC_IDLE, CTCDC_WAIT_TC, CTCDC_ARMED, CTCDC_RUN} ctcdc_chst_t;
  typedef enum logic [1:0] {CTCDC_OP_NONE, CTCDC_OP_ED} ctcdc_opst_t;
endpackage

// ===== verilog/ctcdc_core.sv
`timescale 1ns/1ps
module ctcdc_core
  import ctcdc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // processor bus
  input wire logic io_request_n,
  input wire logic chipEnable_n,
  input wire logic read_n,
  input wire logic opcode_cycle_n,
  input wire logic channel_sel_lo,
  input wire logic channel_sel_hi,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOutEn_n,
  // daisy chain and interrupt
  input wire logic chain_priority_in,
  output logic chain_priority_out,
  output logic irqOut,
  output logic irqOutEn_n,
  // channel pins
  input wire logic [3:0] channel_trigger_in,
  output logic [2:0] zero_count_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    // per-channel pin sync and registers
    logic [3:0][2:0] trigSync;
    logic [3:0][7:0] ctrl;
    logic [3:0][7:0] tconst;
    logic [3:0][7:0] count;
    logic [3:0][7:0] presc;
    logic [3:0][1:0] startDly;
    ctcdc_chst_t [3:0] chState;
    // interrupt bookkeeping
    logic [3:0] pending;
    logic [3:0] inService;
    logic [3:0] ackLatch;
    logic [4:0] vecHi;
    logic [2:0] zc;
    // bus cycle tracking
    logic busPrev;
    logic ackPrev;
    logic fetchPrev;
    ctcdc_opst_t opState;
    // registered bus output
    logic [7:0] dOut;
    logic dOutEn_n;
  } ctcdc_state_t;

  ctcdc_state_t st_ff;
  ctcdc_state_t nxt_st;

  function automatic logic [1:0] prio_code(input logic [3:0] req);
    prio_code = 2'h0;
    for (int i = CTCDC_NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        prio_code = i[1:0];
      end
    end
  endfunction

  function automatic logic [3:0] lower_mask(input logic [3:0] svc);
    lower_mask = 4'h0;
    for (int i = 0; i < CTCDC_NCH; i++) begin
      if (svc[i]) begin
        for (int j = i + 1; j < CTCDC_NCH; j++) begin
          lower_mask[j] = 1'b1;
        end
      end
    end
  endfunction

  // prescaler reload per control word
  function automatic logic [7:0] presc_reload(input logic [7:0] cw);
    presc_reload = cw[CW_PRESC_BIT] ? PRESC_LONG : PRESC_SHORT;
  endfunction

  // edge from the two settled sync stages, per programmed slope
  function automatic logic trig_edge(input logic [2:0] syn, input logic rising);
    if (rising) begin
      trig_edge = syn[1] && !syn[2];
    end else begin
      trig_edge = !syn[1] && syn[2];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] sel;
  logic busCyc;
  logic wrStrobe;
  logic ackCyc;
  logic [3:0] eligible;
  logic anyEligible;
  // read mux of the addressed down-counter
  logic [7:0] selCount;

  assign selCount = st_ff.count[sel];
  assign sel = {channel_sel_hi, channel_sel_lo};
  assign busCyc = !io_request_n && !chipEnable_n && opcode_cycle_n;
  assign wrStrobe = busCyc && read_n;
  assign ackCyc = !io_request_n && !opcode_cycle_n;
  assign eligible = st_ff.pending & ~lower_mask(st_ff.inService) & ~st_ff.inService;
  assign anyEligible = |eligible;

  always_comb begin
    logic trigEdge;
    logic decTick;
    logic [1:0] code;
    nxt_st = st_ff;
    trigEdge = 1'b0;
    decTick = 1'b0;
    code = 2'h0;
    nxt_st.zc = 3'h0;
    nxt_st.busPrev = busCyc;
    nxt_st.ackPrev = ackCyc;
    nxt_st.fetchPrev = !opcode_cycle_n && !read_n && io_request_n;

    // per-channel sync, start and counting
    for (int c = 0; c < CTCDC_NCH; c++) begin
      nxt_st.trigSync[c] = {st_ff.trigSync[c][1:0], channel_trigger_in[c]};
      trigEdge = trig_edge(st_ff.trigSync[c], st_ff.ctrl[c][CW_SLOPE_BIT]);
      decTick = 1'b0;
      unique case (st_ff.chState[c])
        CTCDC_IDLE, CTCDC_WAIT_TC: begin
        end
        CTCDC_ARMED: begin
          if (st_ff.startDly[c] != 2'h0) begin
            nxt_st.startDly[c] = st_ff.startDly[c] - 2'h1;
            if (st_ff.startDly[c] == 2'h1) begin
              nxt_st.chState[c] = CTCDC_RUN;
            end
          end else if (trigEdge || !st_ff.ctrl[c][CW_TRIG_BIT]) begin
            nxt_st.startDly[c] = 2'h1;
          end
        end
        CTCDC_RUN: begin
          if (st_ff.ctrl[c][CW_MODE_BIT]) begin
            decTick = trigEdge;
          end else if (st_ff.presc[c] == 8'h00) begin
            decTick = 1'b1;
            nxt_st.presc[c] = presc_reload(st_ff.ctrl[c]);
          end else begin
            nxt_st.presc[c] = st_ff.presc[c] - 8'h01;
          end
        end
      endcase
      if (decTick) begin
        if (st_ff.count[c] == 8'h01) begin
          nxt_st.count[c] = st_ff.tconst[c];
          if (c < 3) begin
            nxt_st.zc[c] = 1'b1;
          end
          if (st_ff.ctrl[c][CW_IRQ_EN_BIT] && opcode_cycle_n) begin
            nxt_st.pending[c] = 1'b1;
          end
        end else begin
          nxt_st.count[c] = st_ff.count[c] - 8'h01;
        end
      end
      if (!st_ff.ctrl[c][CW_IRQ_EN_BIT] && opcode_cycle_n) begin
        nxt_st.pending[c] = 1'b0;
      end
    end

    // host writes
    // capture on auto wait edge
    if (wrStrobe && st_ff.busPrev) begin
      if (st_ff.chState[sel] == CTCDC_WAIT_TC) begin
        nxt_st.tconst[sel] = dataIn;
        nxt_st.count[sel] = dataIn;
        nxt_st.presc[sel] = presc_reload(st_ff.ctrl[sel]);
        nxt_st.chState[sel] = st_ff.ctrl[sel][CW_MODE_BIT] ? CTCDC_RUN : CTCDC_ARMED;
        nxt_st.startDly[sel] = 2'h0;
      end else if (dataIn[CW_CTRL_BIT]) begin
        nxt_st.ctrl[sel] = dataIn;
        if (dataIn[CW_TC_NEXT_BIT]) begin
          nxt_st.chState[sel] = CTCDC_WAIT_TC;
        end else if (dataIn[CW_SWRST_BIT]) begin
          nxt_st.chState[sel] = CTCDC_IDLE;
        end
      end else if (sel == 2'h0) begin
        nxt_st.vecHi = dataIn[7:VEC_HI_LSB];
      end
    end

    // host reads
    // read leaves count alone
    nxt_st.dOutEn_n = 1'b1;
    if (busCyc && !read_n) begin
      nxt_st.dOut = selCount;
      nxt_st.dOutEn_n = 1'b0;
    end

    // interrupt acknowledge
    // acknowledge vector
    if (ackCyc && chain_priority_in && (anyEligible || st_ff.ackLatch != 4'h0)) begin
      code = prio_code(anyEligible ? eligible : st_ff.ackLatch);
      nxt_st.dOut = {st_ff.vecHi, code, 1'b0};
      nxt_st.dOutEn_n = 1'b0;
      if (!st_ff.ackPrev) begin
        nxt_st.ackLatch = 4'h0;
        nxt_st.ackLatch[code] = 1'b1;
        nxt_st.inService[code] = 1'b1;
        nxt_st.pending[code] = 1'b0;
      end
    end
    if (!ackCyc) begin
      nxt_st.ackLatch = 4'h0;
    end

    // return-from-interrupt watch
    // return opcode decode
    if (nxt_st.fetchPrev && !st_ff.fetchPrev) begin
      if (dataIn == RETURN_FROM_IRQ_OPCODE_BYTE0) begin
        nxt_st.opState = CTCDC_OP_ED;
      end else begin
        if (st_ff.opState == CTCDC_OP_ED && dataIn == RETURN_FROM_IRQ_OPCODE_BYTE1 && chain_priority_in) begin
          nxt_st.inService[prio_code(st_ff.inService)] = 1'b0;
        end
        nxt_st.opState = CTCDC_OP_NONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int c = 0; c < CTCDC_NCH; c++) begin
        st_ff.trigSync[c] <= 3'h0;
        st_ff.ctrl[c] <= RST_CTRL;
        st_ff.tconst[c] <= RST_COUNT;
        st_ff.count[c] <= RST_COUNT;
        st_ff.presc[c] <= 8'h00;
        st_ff.startDly[c] <= 2'h0;
        st_ff.chState[c] <= CTCDC_IDLE;
      end
      // nothing pending or under service
      st_ff.pending <= 4'h0;
      st_ff.inService <= 4'h0;
      st_ff.ackLatch <= 4'h0;
      st_ff.vecHi <= RST_VEC_HI;
      st_ff.zc <= 3'h0;
      st_ff.busPrev <= 1'b0;
      st_ff.ackPrev <= 1'b0;
      st_ff.fetchPrev <= 1'b0;
      st_ff.opState <= CTCDC_OP_NONE;
      // data bus floated
      st_ff.dOut <= 8'h00;
      st_ff.dOutEn_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign dataOut = st_ff.dOut;
  assign dataOutEn_n = st_ff.dOutEn_n;
  assign chain_priority_out = chain_priority_in && (st_ff.inService == 4'h0);
  assign irqOut = 1'b0;
  assign irqOutEn_n = !(anyEligible && chain_priority_in);
  assign zero_count_pulse = st_ff.zc;

endmodule // ctcdc_core

// ===== verification/ctcdc_sva.sv
`timescale 1ns/1ps
module ctcdc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic io_request_n,
  input wire logic chipEnable_n,
  input wire logic read_n,
  input wire logic opcode_cycle_n,
  input wire logic [7:0] dataOut,
  input wire logic dataOutEn_n,
  // chain and pins
  input wire logic chain_priority_in,
  input wire logic chain_priority_out,
  input wire logic irqOutEn_n,
  input wire logic [2:0] zero_count_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_chain_gate: assert property (!chain_priority_in |-> !chain_priority_out)
    else $error("chain out high");
  a_reset_idle: assert property ($rose(rst_n) |-> irqOutEn_n && dataOutEn_n &&
    !zero_count_pulse && chain_priority_out == chain_priority_in) else $error("reset state");
  a_zc_single: assert property (!(zero_count_pulse & $past(zero_count_pulse)))
    else $error("long pulse");
  a_read_drive: assert property (!io_request_n && !chipEnable_n && !read_n && opcode_cycle_n
    |=> !dataOutEn_n) else $error("read undriven");
  a_write_quiet: assert property (!io_request_n && !chipEnable_n && read_n && opcode_cycle_n
    |=> dataOutEn_n) else $error("write drives");
  a_bus_release: assert property (io_request_n |=> dataOutEn_n)
    else $error("bus held");
  a_ack_refused: assert property (!opcode_cycle_n && !io_request_n && !chain_priority_in
    |=> dataOutEn_n) else $error("vector without chain");
  a_irq_freeze: assert property ((!opcode_cycle_n && io_request_n && read_n) [*2]
    |-> $stable(irqOutEn_n)) else $error("irq moved");
  a_vec_zero: assert property (!opcode_cycle_n && !io_request_n && chain_priority_in
    ##1 !dataOutEn_n |-> !dataOut[0]) else $error("vector bit0");
  c_zero: cover property (|zero_count_pulse);
  c_vector: cover property (!dataOutEn_n && !opcode_cycle_n);
  c_read: cover property (!dataOutEn_n && opcode_cycle_n);
endmodule // ctcdc_sva
////////////////////////////////////////
bind ctcdc_core ctcdc_sva u_sva (.*);

// ===== verification/ctcdc_cpu.sv
`timescale 1ns/1ps
module ctcdc_cpu (
  // clock
  input wire logic clk,
  // strobes and data
  output logic io_request_n,
  output logic chipEnable_n,
  output logic read_n,
  output logic opcode_cycle_n,
  output logic channel_sel_lo,
  output logic channel_sel_hi,
  output logic [7:0] dataIn,
  // answer
  input wire logic [7:0] dataOut,
  input wire logic dataOutEn_n
);
  initial begin
    {opcode_cycle_n, io_request_n, chipEnable_n, read_n} = 4'hf;
    {channel_sel_hi, channel_sel_lo} = 2'h0;
    dataIn = 8'h00;
  end
  task automatic cyc(input logic [3:0] s, input logic [1:0] ch, input logic [7:0] d, input int n,
    output logic [8:0] q);
    @(negedge clk);
    {opcode_cycle_n, io_request_n, chipEnable_n, read_n} = s;
    {channel_sel_hi, channel_sel_lo} = ch;
    dataIn = (!s[2] && !(s[0] && s[3])) ? ~dataIn : d;
    repeat (n) @(posedge clk);
    q = {dataOutEn_n, dataOut};
  endtask
  // released bus shows no stale value
  task automatic idle();
    @(negedge clk);
    {opcode_cycle_n, io_request_n, chipEnable_n, read_n} = 4'hf;
    dataIn = ~dataIn;
  endtask
endmodule // ctcdc_cpu

// ===== verification/test_counter_timer_bus_and_daisy_chain.sv
`timescale 1ns/1ps
module test_counter_timer_bus_and_daisy_chain import ctcdc_pkg::*;;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic chain_priority_in = 1'h1;
  logic [3:0] channel_trigger_in = 4'h0;
  logic io_request_n, chipEnable_n, read_n, opcode_cycle_n, channel_sel_lo, channel_sel_hi;
  logic dataOutEn_n, chain_priority_out, irqOut, irqOutEn_n;
  logic [7:0] dataIn, dataOut;
  logic [2:0] zero_count_pulse;
  logic [8:0] q;
  int bad_count = 0;
  int n_tests = 0;
  int k;
  int zcSeen [4] = '{0, 0, 0, 0};
  // time constant, count after one trigger
  logic [15:0] rows [4] = '{16'h0302, 16'h0201, 16'h0403, 16'h0504};
  always #20 clk = ~clk;
  ctcdc_core uut (.*);
  ctcdc_cpu cpu (.*);
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) zcSeen[i] += int'(zero_count_pulse[i]);
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [3:0] s, input logic [1:0] ch, input logic [7:0] d);
    cpu.cyc(s, ch, d, 2, q);
    cpu.idle();
  endtask
  task automatic ack();
    cpu.cyc(4'h7, 2'h0, 8'h00, 2, q);
    bus(4'h3, 2'h0, 8'h00);
  endtask
  task automatic trig(input int ch, input int n);
    repeat (n) begin
      @(negedge clk);
      channel_trigger_in[ch] = 1'h1;
      repeat (2) @(negedge clk);
      channel_trigger_in[ch] = 1'h0;
      @(negedge clk);
    end
    repeat (6) @(negedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    chk("idle", 9'h38, {3'h0, irqOutEn_n, dataOutEn_n, chain_priority_out, zero_count_pulse});
    for (int c = 0; c < 4; c++) begin
      bus(4'h9, 2'(c), 8'h55);
      bus(4'h9, 2'(c), rows[c][15:8]);
      trig(c, 1);
      repeat (2) begin
        bus(4'h8, 2'(c), 8'h00);
        chk("count", {1'h0, rows[c][7:0]}, q);
      end
      trig(c, int'(rows[c][7:0]));
      chk("zero pulses", 9'(c < 3), 9'(zcSeen[c]));
    end
    bus(4'h9, 2'h0, 8'ha8);
    for (int c = 1; c < 3; c++) begin
      bus(4'h9, 2'(c), 8'hd5);
      bus(4'h9, 2'(c), 8'h02);
    end
    trig(2, 2);
    trig(1, 2);
    chk("irq", 9'h0, {7'h0, irqOut, irqOutEn_n});
    chain_priority_in = 1'h0;
    ack();
    chk("refused", 9'h1, {8'h0, q[8]});
    chain_priority_in = 1'h1;
    ack();
    chk("vector", 9'h0aa, q);
    chk("chain out", 9'h0, {8'h0, chain_priority_out});
    chk("lower held", 9'h1, {8'h0, irqOutEn_n});
    bus(4'h6, 2'h0, RETURN_FROM_IRQ_OPCODE_BYTE0);
    bus(4'h6, 2'h0, RETURN_FROM_IRQ_OPCODE_BYTE1);
    chk("chain back", 9'h1, {8'h0, chain_priority_out});
    ack();
    chk("vector", 9'h0ac, q);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk("idle", 9'h38, {3'h0, irqOutEn_n, dataOutEn_n, chain_priority_out, zero_count_pulse});
    trig(1, 2);
    chk("irq off", 9'h1, {8'h0, irqOutEn_n});
    bus(4'h9, 2'h0, 8'h05);
    bus(4'h9, 2'h0, 8'h01);
    @(posedge zero_count_pulse[0]);
    @(negedge clk);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!zero_count_pulse[0]);
    chk("timer period", 9'h010, 9'(k));
    conclude();
  end
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule // test_counter_timer_bus_and_daisy_chain
